//--- rpc_map.vh
// constants for the rs485 port control block
`ifndef RPC_MAP_VH
`define RPC_MAP_VH
// interface mode codes
`define RPC_MODE_RS232      2'h0
`define RPC_MODE_RS422      2'h1
`define RPC_MODE_RS485      2'h2
`define RPC_MODE_DEFAULT    2'h1
// enable/clock switch bit positions (switch position n sits at bit n-1)
`define RPC_SW_FULL_RATE    0
`define RPC_SW_QUARTER_RATE 1
`define RPC_SW_AUTO_EN      2
`define RPC_SW_RTS_EN       3
// interface switch bit of the no-echo position 9
`define RPC_SW_NO_ECHO      8
// fifo depth in bytes
`define RPC_FIFO_DEPTH      128
// baud clock divide ratio in quarter-rate mode
`define RPC_QUARTER_DIV     4
`endif

//--- rpc_baud_div.v
// baud clock divider: pass-through or divide by four
`timescale 1ns/100ps
`include "rpc_map.vh"
module rpc_baud_div #(
  parameter DIV = `RPC_QUARTER_DIV
) (
  // clock and reset
  input  wire clock,
  input  wire rstn,
  // control
  input  wire quarter_rate_clock_mode,
  input  wire full_rate_clock_mode,
  // baud clock enable in and out
  input  wire baud_tick_in,
  output reg  baud_tick_out
);

  reg [7:0] count;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count         <= 8'h00;
      baud_tick_out <= 1'b0;
    end else if (quarter_rate_clock_mode && !full_rate_clock_mode) begin
      baud_tick_out <= 1'b0;
      if (baud_tick_in) begin
        if (count == DIV - 1) begin
          count         <= 8'h00;
          baud_tick_out <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end else begin
      // full rate wins when both positions are on
      count         <= 8'h00;
      baud_tick_out <= baud_tick_in;
    end
  end

endmodule // rpc_baud_div

//--- rpc_port_ctrl.v
// per-port serial line control: mode select, rs485 driver enable, echo, baud clock
`timescale 1ns/100ps
`include "rpc_map.vh"
module rpc_port_ctrl #(
  parameter FIFO_DEPTH = `RPC_FIFO_DEPTH
) (
  // clock and reset
  input  wire       clock,
  input  wire       rstn,
  // static switches
  input  wire [1:0] mode_switches,
  input  wire       mode_switches_valid,
  input  wire [8:0] port_interface_switches,
  input  wire [3:0] port_enable_clock_switches,
  // uart side
  input  wire       uart_rts,
  input  wire       uart_tx_busy,
  input  wire       uart_tx_data,
  input  wire       uart_baud_tick,
  // line side
  input  wire       line_rx_data,
  // outputs to line interface, uart and host
  output reg  [1:0] interface_mode,
  output reg        line_tx_data,
  output reg        line_tx_oe,
  output reg        uart_rx_data,
  output reg        rx_enable,
  output reg        uart_baud_tick_out,
  output reg  [7:0] fifo_depth_bytes
);

  // ****************************************
  // switch decode
  // ****************************************
  wire rts_keyed_driver_enable = port_enable_clock_switches[`RPC_SW_RTS_EN];
  wire automatic_driver_enable = port_enable_clock_switches[`RPC_SW_AUTO_EN];
  wire quarter_rate_clock_mode = port_enable_clock_switches[`RPC_SW_QUARTER_RATE];
  wire full_rate_clock_mode    = port_enable_clock_switches[`RPC_SW_FULL_RATE];
  wire no_echo                 = port_interface_switches[`RPC_SW_NO_ECHO];

  // ****************************************
  // interface mode
  // ****************************************
  // an unset switch code falls back to the factory mode
  // a low valid flag means no switch block is fitted at all
  reg [1:0] next_mode;
  always @* begin
    if (!mode_switches_valid) begin
      next_mode = `RPC_MODE_DEFAULT;
    end else if (mode_switches == `RPC_MODE_RS232) begin
      next_mode = `RPC_MODE_RS232;
    end else if (mode_switches == `RPC_MODE_RS422) begin
      next_mode = `RPC_MODE_RS422;
    end else if (mode_switches == `RPC_MODE_RS485) begin
      next_mode = `RPC_MODE_RS485;
    end else begin
      next_mode = `RPC_MODE_DEFAULT;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interface_mode <= `RPC_MODE_DEFAULT;
    end else begin
      interface_mode <= next_mode;
    end
  end

  // ****************************************
  // mode one-hot
  // ****************************************
  // decoded from the next mode, not the registered one, so the driver and
  // receiver gates switch on the same edge as interface_mode
  // code 3 never shows here, the decode above has already folded it
  wire [2:0] mode_hot;
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_mode_hot
      localparam [1:0] CODE = k;
      assign mode_hot[k] = (next_mode == CODE);
    end
  endgenerate

  wire is_485 = mode_hot[`RPC_MODE_RS485];

  // ****************************************
  // driver enable
  // ****************************************
  // auto enable rises with the shifter busy flag, which covers the start bit,
  // and falls only when busy clears after the final stop bit
  // in rs485 mode with no key source selected the driver stays off, so a half-set port never fights the line
  // rts-keyed is tested first, so it wins when both key switches are on
  reg next_oe;
  always @* begin
    if (mode_hot[`RPC_MODE_RS232] || mode_hot[`RPC_MODE_RS422]) begin
      next_oe = 1'b1;
    end else if (rts_keyed_driver_enable) begin
      next_oe = uart_rts;
    end else if (automatic_driver_enable) begin
      next_oe = uart_tx_busy;
    end else begin
      next_oe = 1'b0;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line_tx_oe <= 1'b0;
    end else begin
      line_tx_oe <= next_oe;
    end
  end

  // ****************************************
  // transmit data
  // ****************************************
  // one flop of delay keeps the data aligned with the registered enable
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line_tx_data <= 1'b1;
    end else begin
      line_tx_data <= uart_tx_data;
    end
  end

  // ****************************************
  // receiver enable and echo
  // ****************************************
  // compare against next_oe so the gate opens and closes with the driver
  reg next_rx_en;
  always @* begin
    if (is_485 && no_echo && next_oe) begin
      next_rx_en = 1'b0;
    end else begin
      next_rx_en = 1'b1;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_enable <= 1'b1;
    end else begin
      rx_enable <= next_rx_en;
    end
  end

  // ****************************************
  // receive data
  // ****************************************
  // hold the line at mark while gagged so the uart never sees a false start bit
  reg next_rx_data;
  always @* begin
    if (next_rx_en) begin
      next_rx_data = line_rx_data;
    end else begin
      next_rx_data = 1'b1;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      uart_rx_data <= 1'b1;
    end else begin
      uart_rx_data <= next_rx_data;
    end
  end

  // ****************************************
  // baud clock
  // ****************************************
  // is up to host software; the divider only sets the base rate
  // the divider has its own flop, so each tick it passes reaches the uart two clocks late
  wire div_tick;
  rpc_baud_div #(
    .DIV(`RPC_QUARTER_DIV)
  ) u_div (
    .clock                   (clock),
    .rstn                    (rstn),
    .quarter_rate_clock_mode (quarter_rate_clock_mode),
    .full_rate_clock_mode    (full_rate_clock_mode),
    .baud_tick_in            (uart_baud_tick),
    .baud_tick_out           (div_tick)
  );

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      uart_baud_tick_out <= 1'b0;
    end else begin
      uart_baud_tick_out <= div_tick;
    end
  end

  // ****************************************
  // fifo depth
  // ****************************************
  // the fifos live in the uart; this only reports their depth to the host
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fifo_depth_bytes <= 8'h00;
    end else begin
      fifo_depth_bytes <= FIFO_DEPTH[7:0];
    end
  end

endmodule // rpc_port_ctrl

//--- rpc_sva.sv
// assertion checker for the port control block
`timescale 1ns/100ps
module rpc_sva (
  input wire       clock, rstn, mode_switches_valid, uart_rts, uart_tx_busy, uart_baud_tick,
  input wire       line_tx_oe, uart_rx_data, rx_enable, uart_baud_tick_out,
  input wire [1:0] mode_switches, interface_mode,
  input wire [3:0] port_enable_clock_switches,
  input wire [8:0] port_interface_switches,
  input wire [7:0] fifo_depth_bytes
);
  wire [1:0] m = mode_switches;
  wire v = mode_switches_valid;
  wire [3:0] e = port_enable_clock_switches;
  wire r = v && m == 2'h2;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_MODE: assert property (v && m != 2'h3 |=> interface_mode == $past(m))
    else $error("mode");
  AST_OE_ON: assert property (v && m < 2'h2 |=> line_tx_oe)
    else $error("driver off");
  AST_RTS: assert property (r && e[3] |=> line_tx_oe == $past(uart_rts))
    else $error("rts enable");
  AST_AUTO: assert property (r && e[3:2] == 2'h1 |=> line_tx_oe == $past(uart_tx_busy))
    else $error("auto enable");
  AST_TRI: assert property (r && e[3:2] == 2'h0 |=> !line_tx_oe)
    else $error("driver on");
  AST_RX: assert property (rx_enable != (interface_mode == 2'h2 && line_tx_oe
    && $past(port_interface_switches[8]))) else $error("rx enable");
  AST_HOLD: assert property (!rx_enable |-> uart_rx_data)
    else $error("rx not held");
  AST_BAUD: assert property (uart_baud_tick && (e[0] || !e[1]) |-> ##2 uart_baud_tick_out)
    else $error("tick lost");
  AST_DEPTH: assert property ($past(rstn) |-> fifo_depth_bytes == 8'h80)
    else $error("depth");
  cover property (line_tx_oe && !rx_enable);
  cover property (uart_baud_tick_out);
  cover property ($rose(line_tx_oe));
endmodule // rpc_sva
bind rpc_port_ctrl rpc_sva u_sva (.*);

//--- rpc_line_peer.sv
// line-side peer node model
`timescale 1ns/100ps
module rpc_line_peer (
  input  wire clock,
  input  wire line_tx_data,
  input  wire line_tx_oe,
  output reg  line_rx_data = 1'b1
);
  // echoes the port's data while the port drives; a free line shows a changing pattern
  always @(posedge clock) line_rx_data <= line_tx_oe ? line_tx_data : ~line_rx_data;
endmodule // rpc_line_peer

//--- tb_top.sv
// testbench for the port control block
`timescale 1ns/100ps
module tb_top;
  reg clock = 0, rstn = 0, mode_switches_valid = 1, uart_rts = 0, uart_tx_busy = 0, x;
  reg uart_tx_data = 1, uart_baud_tick = 0;
  reg [1:0] mode_switches = 2'h1;
  reg [8:0] port_interface_switches = 9'h000;
  reg [3:0] port_enable_clock_switches = 4'h0;
  wire [1:0] interface_mode;
  wire [7:0] fifo_depth_bytes;
  wire line_tx_data, line_tx_oe, uart_rx_data, rx_enable, uart_baud_tick_out, line_rx_data;
  integer errors = 0, check_count = 0, n = 0, i;
  always #2.5 clock = ~clock;
  always @(posedge clock) n <= n + uart_baud_tick_out;
  rpc_port_ctrl dut (.*);
  rpc_line_peer peer (.*);
  task chk(input [31:0] s, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %0s exp %0h got %0h", s, e, g);
      end
    end
  endtask
  task drv(input [1:0] m, input [3:0] e, input s, input r, input b);
    begin
      @(posedge clock);
      mode_switches <= m;
      port_enable_clock_switches <= e;
      port_interface_switches <= {s, 8'h00};
      uart_rts <= r;
      uart_tx_busy <= b;
      uart_tx_data <= ~uart_tx_data;
      @(posedge clock) #1;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000 errors = errors + 1;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1;
    @(posedge clock) #1;
    chk("mode", 1, interface_mode);
    chk("dep", 128, fifo_depth_bytes);
    for (i = 0; i < 4; i = i + 1) begin
      drv(i[1:0], 0, 0, 0, 0);
      chk("mode", i == 3 ? 1 : i, interface_mode);
      chk("oe", i != 2, line_tx_oe);
      chk("txd", uart_tx_data, line_tx_data);
      if (i < 2) chk("rxd", !uart_tx_data, uart_rx_data);
    end
    $display("test modes done");
    for (i = 0; i < 8; i = i + 1) begin
      x = i[2] ? i[1] : i[0];
      drv(2, i[2] ? 4'h4 : 4'hC, 1, i[0], i[1]);
      chk("oe", x, line_tx_oe);
      chk("rxen", !x, rx_enable);
      if (x) chk("rxd", 1, uart_rx_data);
    end
    drv(2, 4'h4, 0, 0, 1);
    chk("rxen", 1, rx_enable);
    drv(2, 0, 0, 1, 1);
    chk("oe", 0, line_tx_oe);
    @(posedge clock) mode_switches_valid <= 0;
    drv(2, 0, 0, 0, 0);
    chk("mode", 1, interface_mode);
    $display("test driver done");
    for (i = 1; i < 4; i = i + 1) begin
      drv(2, i[3:0], 0, 0, 0);
      n = 0;
      repeat (8) begin
        @(posedge clock) uart_baud_tick <= 1;
        @(posedge clock) uart_baud_tick <= 0;
      end
      repeat (3) @(posedge clock);
      #1 chk("tick", i == 2 ? 2 : 8, n);
    end
    $display("test baud done");
    stop_test;
  end
endmodule // tb_top
